// *** logic/vpsc_consts.svh ***
// Offsets, field positions and timing counts of the video port status block
`ifndef VPSC_CONSTS_SVH
`define VPSC_CONSTS_SVH

`define VPSC_OFS_STATUS    16'hff04
`define VPSC_OFS_IRQ       16'hff08
`define VPSC_OFS_BASE0     16'hff0c
`define VPSC_OFS_BASE1     16'hff10
`define VPSC_OFS_XADDR     16'hff14
`define VPSC_OFS_XDATA     16'hff18
`define VPSC_OFS_NIBBLE    16'hff1c
`define VPSC_OFS_LINES     16'hff20
`define VPSC_OFS_OFIFO     16'hff40
`define VPSC_OFIFO_MASK    16'hffe0

`define VPSC_ST_FULL       11
`define VPSC_ST_EMPTY      12
`define VPSC_ST_ONE        13
`define VPSC_ST_PARITY     20
`define VPSC_ST_BASESEL    21
`define VPSC_ST_VF0_ONE    22
`define VPSC_ST_VF1_FULL   29
`define VPSC_ST_VF1_EMPTY  30
`define VPSC_ST_VF1_ONE    31

`define VPSC_IRQ_MASK_LSB  16
`define VPSC_IRQ_STRETCH   24

`define VPSC_LN_CLK_DRV    0
`define VPSC_LN_DAT_DRV    1
`define VPSC_LN_ENABLE     4
`define VPSC_LN_MIRROR_LSB 8

`define VPSC_XA_KIND_LSB   21
`define VPSC_NB_IN_LSB     4

`define VPSC_STROBE_NS     40
`define VPSC_SYS_CLK_MHZ   100
`define VPSC_STROBE_CYC    ((`VPSC_STROBE_NS * `VPSC_SYS_CLK_MHZ + 999) / 1000)

`endif

// *** logic/vpsc_pkg.sv ***
// Types shared by the video port status and control block
package vpsc_pkg;
  typedef enum logic [2:0] {
    VPSC_TK_REG_WR   = 3'h0,
    VPSC_TK_REG_RD   = 3'h1,
    VPSC_TK_CDATA_WR = 3'h6
  } vpsc_kind_t;

  typedef enum logic {
    VPSC_XS_IDLE,
    VPSC_XS_BUSY
  } vpsc_xstate_t;
endpackage

// *** logic/vpsc_link.sv ***
// Link-clock side: decoder transaction handshake and sync edge capture
module vpsc_link (
  input  logic                 link_clk,
  input  logic                 reset_n,
  input  logic                 req_tgl,
  input  vpsc_pkg::vpsc_kind_t req_kind,
  input  logic [20:0]          req_addr,
  input  logic [31:0]          req_wdata,
  output logic                 ack_tgl,
  output logic [31:0]          link_rdata,
  output logic                 line_tgl,
  output logic                 frame_tgl,
  input  logic                 hsync_pin,
  input  logic                 vsync_pin,
  output logic                 dec_req,
  output vpsc_pkg::vpsc_kind_t dec_kind,
  output logic [20:0]          dec_addr,
  output logic [31:0]          dec_wdata,
  input  logic                 dec_ack,
  input  logic [31:0]          dec_rdata
);
  import vpsc_pkg::*;

  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        ack_tgl;
    logic [31:0] rdata;
    logic        hs_d;
    logic        vs_d;
    logic        line_tgl;
    logic        frame_tgl;
    logic        dec_req;
    vpsc_kind_t  kind;
    logic [20:0] addr;
    logic [31:0] wdata;
  } vpsc_lst_t;

  vpsc_lst_t r;
  vpsc_lst_t n;
  logic      lrs1_r;
  logic      lrs2_r;

  // System reset brought into this domain
  always_ff @(posedge link_clk) begin
    lrs1_r <= reset_n;
    lrs2_r <= lrs1_r;
  end

  always_comb begin
    n = r;
    n.req_s1 = req_tgl;
    n.req_s2 = r.req_s1;
    // Request words are held still by the system side until the ack returns
    if (!r.dec_req && (r.req_s2 != r.ack_tgl)) begin
      n.dec_req = 1'b1;
      n.kind    = req_kind;
      n.addr    = req_addr;
      n.wdata   = req_wdata;
    end else if (r.dec_req && dec_ack) begin
      n.dec_req = 1'b0;
      n.rdata   = dec_rdata;
      n.ack_tgl = ~r.ack_tgl;
    end
    n.hs_d = hsync_pin;
    n.vs_d = vsync_pin;
    if (hsync_pin && !r.hs_d) begin
      n.line_tgl = ~r.line_tgl;
    end
    if (vsync_pin && !r.vs_d) begin
      n.frame_tgl = ~r.frame_tgl;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrs2_r) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ack_tgl    = r.ack_tgl;
  assign link_rdata = r.rdata;
  assign line_tgl   = r.line_tgl;
  assign frame_tgl  = r.frame_tgl;
  assign dec_req    = r.dec_req;
  assign dec_kind   = r.kind;
  assign dec_addr   = r.addr;
  assign dec_wdata  = r.wdata;
endmodule

// *** logic/vpsc_video_port.sv ***
// Video port status, interrupt flags, base addresses, indirect access and nibble port
// Notes on behaviour
// - Status reports free output FIFO word slots as binary count zero to eight.
// - Output FIFO full bit is set while every slot is occupied.
// - Output FIFO empty bit is set while no slot holds data.
// - Output FIFO one-left bit is set only with exactly one slot filled.
// - Status shows the live field parity pin level.
// - Status shows which frame buffer base address is selected.
// - Video FIFO 0 one-left bit set exactly with one slot filled.
// - Video FIFO 1 has full, empty and one-left status bits.
// - Output FIFO empty flag latches when the FIFO becomes empty.
// - Line end flag latches on each horizontal sync received.
// - Frame end flag latches on each vertical sync received.
// - Start flag latches when data line falls while clock line is high and the data line is not driven by us.
// - Writing one clears a latched flag; writing zero leaves it.
// - Four mask bits enable the four interrupts; zero disables.
// - Stretch enable holds the clock line low after a start until released.
// - Indirect address holds 21-bit address and 3-bit transaction kind.
// - Hardware issues compressed data writes for output FIFO contents.
// - Writing the indirect data register launches a decoder transaction.
// - Nibble port write drives low data lines and pulses strobe low.
// - Upper data lines are latched into input bits during the strobe.
// - Clock drive bit zero drives the clock line low while line enable is set; one releases it.
`include "vpsc_consts.svh"

module vpsc_video_port #(
  parameter int OFIFO_DEPTH = 8,
  parameter int VID_DEPTH   = 8,
  parameter int LVL_W       = 4
) (
  input  logic                 sys_clk,
  input  logic                 reset_n,
  input  logic                 link_clk,
  input  logic [15:0]          reg_addr,
  input  logic                 reg_wr_en,
  input  logic                 reg_rd_en,
  input  logic [31:0]          reg_wdata,
  output logic [31:0]          reg_rdata,
  output logic                 irq_req,
  input  logic [LVL_W-1:0]     vid_fifo0_level,
  input  logic [LVL_W-1:0]     vid_fifo1_level,
  input  logic                 field_parity_pin,
  input  logic                 hsync_pin,
  input  logic                 vsync_pin,
  input  logic                 two_wire_clock_line_i,
  output logic                 two_wire_clock_line_o,
  output logic                 two_wire_clock_line_oe,
  input  logic                 two_wire_data_line_i,
  output logic                 two_wire_data_line_o,
  output logic                 two_wire_data_line_oe,
  input  logic [7:0]           port_data_lines_i,
  output logic [7:0]           port_data_lines_o,
  output logic [7:0]           port_data_lines_oe,
  output logic                 nibble_port_strobe_n,
  output logic [21:0]          active_base_addr,
  output logic                 dec_req,
  output vpsc_pkg::vpsc_kind_t dec_kind,
  output logic [20:0]          dec_addr,
  output logic [31:0]          dec_wdata,
  input  logic                 dec_ack,
  input  logic [31:0]          dec_rdata
);
  import vpsc_pkg::*;

  localparam int PW = $clog2(OFIFO_DEPTH);
  localparam int CW = $clog2(OFIFO_DEPTH + 1);

  typedef struct packed {
    logic [OFIFO_DEPTH-1:0][31:0] mem;
    logic [PW-1:0]                wp;
    logic [PW-1:0]                rp;
    logic [CW-1:0]                cnt;
    logic [3:0]                   flags;
    logic [3:0]                   mask;
    logic                         stretch_en;
    logic                         stretch;
    logic [21:0]                  base0;
    logic [21:0]                  base1;
    logic                         base1_set;
    logic                         base_sel;
    logic [21:0]                  act_base;
    logic [20:0]                  xaddr;
    logic [2:0]                   xkind;
    logic [31:0]                  xdata;
    logic                         x_pend;
    logic                         x_cdata;
    vpsc_xstate_t                 xs;
    logic                         req_tgl;
    logic                         ack_s1;
    logic                         ack_s2;
    vpsc_kind_t                   lk_kind;
    logic [20:0]                  lk_addr;
    logic [31:0]                  lk_wdata;
    logic                         ln_s1;
    logic                         ln_s2;
    logic                         ln_d;
    logic                         fr_s1;
    logic                         fr_s2;
    logic                         fr_d;
    logic                         par_s1;
    logic                         par_s2;
    logic                         cl_s1;
    logic                         cl_s2;
    logic                         dl_s1;
    logic                         dl_s2;
    logic                         dl_d;
    logic                         ln_en;
    logic                         clk_drv;
    logic                         dat_drv;
    logic                         clk_oe;
    logic                         dat_oe;
    logic [3:0]                   nb_out;
    logic [3:0]                   nb_in;
    logic [3:0]                   nb_s1;
    logic [3:0]                   nb_s2;
    logic [2:0]                   nb_cnt;
    logic                         strobe_n;
    logic                         nb_oe;
    logic [31:0]                  rdata;
    logic                         irq;
  } vpsc_st_t;

  vpsc_st_t    r;
  vpsc_st_t    n;
  logic        push;
  logic        pop;
  logic [3:0]  clr;
  logic [3:0]  set;
  logic        line_evt;
  logic        frame_evt;
  logic        start_evt;
  logic [31:0] stat_w;
  logic [4:0]  line_w;
  logic        ack_tgl;
  logic [31:0] link_rdata;
  logic        line_tgl;
  logic        frame_tgl;

  function automatic logic is_ofifo(input logic [15:0] a);
    return (a & `VPSC_OFIFO_MASK) == `VPSC_OFS_OFIFO;
  endfunction

  vpsc_link u_link (
    .link_clk   (link_clk),
    .reset_n    (reset_n),
    .req_tgl    (r.req_tgl),
    .req_kind   (r.lk_kind),
    .req_addr   (r.lk_addr),
    .req_wdata  (r.lk_wdata),
    .ack_tgl    (ack_tgl),
    .link_rdata (link_rdata),
    .line_tgl   (line_tgl),
    .frame_tgl  (frame_tgl),
    .hsync_pin  (hsync_pin),
    .vsync_pin  (vsync_pin),
    .dec_req    (dec_req),
    .dec_kind   (dec_kind),
    .dec_addr   (dec_addr),
    .dec_wdata  (dec_wdata),
    .dec_ack    (dec_ack),
    .dec_rdata  (dec_rdata)
  );

  always_comb begin
    stat_w = '0;
    stat_w[3:0] = 4'(OFIFO_DEPTH - int'(r.cnt));
    stat_w[`VPSC_ST_FULL]  = (r.cnt == CW'(OFIFO_DEPTH));
    stat_w[`VPSC_ST_EMPTY] = (r.cnt == '0);
    stat_w[`VPSC_ST_ONE]   = (r.cnt == CW'(1));
    stat_w[`VPSC_ST_PARITY]  = r.par_s2;
    stat_w[`VPSC_ST_BASESEL] = r.base_sel;
    stat_w[`VPSC_ST_VF0_ONE] = (vid_fifo0_level == LVL_W'(1));
    stat_w[`VPSC_ST_VF1_FULL]  = (vid_fifo1_level == LVL_W'(VID_DEPTH));
    stat_w[`VPSC_ST_VF1_EMPTY] = (vid_fifo1_level == '0);
    stat_w[`VPSC_ST_VF1_ONE]   = (vid_fifo1_level == LVL_W'(1));
    line_w = {r.ln_en, r.dl_s2, r.cl_s2, r.dat_drv, r.clk_drv};
  end

  always_comb begin
    n    = r;
    push = 1'b0;
    pop  = 1'b0;
    clr  = 4'h0;
    n.ln_s1  = line_tgl;
    n.ln_s2  = r.ln_s1;
    n.ln_d   = r.ln_s2;
    n.fr_s1  = frame_tgl;
    n.fr_s2  = r.fr_s1;
    n.fr_d   = r.fr_s2;
    n.par_s1 = field_parity_pin;
    n.par_s2 = r.par_s1;
    n.cl_s1  = two_wire_clock_line_i;
    n.cl_s2  = r.cl_s1;
    n.dl_s1  = two_wire_data_line_i;
    n.dl_s2  = r.dl_s1;
    n.dl_d   = r.dl_s2;
    n.ack_s1 = ack_tgl;
    n.ack_s2 = r.ack_s1;
    n.nb_s1  = port_data_lines_i[7:4];
    n.nb_s2  = r.nb_s1;
    line_evt  = r.ln_s2 ^ r.ln_d;
    frame_evt = r.fr_s2 ^ r.fr_d;
    // Our own data drive must not fake a start
    start_evt = r.dl_d & ~r.dl_s2 & r.cl_s2 & ~r.dat_oe;

    if (!r.strobe_n) begin
      n.nb_cnt = r.nb_cnt - 3'h1;
      if (r.nb_cnt == 3'h1) begin
        n.strobe_n = 1'b1;
        n.nb_oe    = 1'b0;
        n.nb_in    = r.nb_s2;
      end
    end

    // Software requests take priority over draining the output FIFO
    unique case (r.xs)
      VPSC_XS_IDLE: begin
        if (r.x_pend || (r.cnt != '0)) begin
          n.xs       = VPSC_XS_BUSY;
          n.req_tgl  = ~r.req_tgl;
          n.lk_addr  = r.xaddr;
          n.x_cdata  = !r.x_pend;
          n.lk_kind  = r.x_pend ? vpsc_kind_t'(r.xkind) : VPSC_TK_CDATA_WR;
          n.lk_wdata = r.x_pend ? r.xdata : r.mem[r.rp];
          n.x_pend   = 1'b0;
        end
      end
      VPSC_XS_BUSY: begin
        if (r.ack_s2 == r.req_tgl) begin
          n.xs = VPSC_XS_IDLE;
          pop  = r.x_cdata;
          if (!r.x_cdata && (r.lk_kind == VPSC_TK_REG_RD)) begin
            n.xdata = link_rdata;
          end
        end
      end
    endcase

    if (reg_wr_en) begin
      case (reg_addr)
        `VPSC_OFS_IRQ: begin
          clr          = reg_wdata[3:0];
          n.mask       = reg_wdata[`VPSC_IRQ_MASK_LSB +: 4];
          n.stretch_en = reg_wdata[`VPSC_IRQ_STRETCH];
        end
        `VPSC_OFS_BASE0: n.base0 = reg_wdata[21:0];
        `VPSC_OFS_BASE1: begin
          n.base1     = reg_wdata[21:0];
          n.base1_set = 1'b1;
        end
        `VPSC_OFS_XADDR: begin
          n.xaddr = reg_wdata[20:0];
          n.xkind = reg_wdata[`VPSC_XA_KIND_LSB +: 3];
        end
        `VPSC_OFS_XDATA: begin
          n.xdata  = reg_wdata;
          n.x_pend = 1'b1;
        end
        `VPSC_OFS_NIBBLE: begin
          n.nb_out   = reg_wdata[3:0];
          n.nb_oe    = 1'b1;
          n.strobe_n = 1'b0;
          n.nb_cnt   = 3'(`VPSC_STROBE_CYC);
        end
        `VPSC_OFS_LINES: begin
          n.clk_drv = reg_wdata[`VPSC_LN_CLK_DRV];
          n.dat_drv = reg_wdata[`VPSC_LN_DAT_DRV];
          n.ln_en   = reg_wdata[`VPSC_LN_ENABLE];
        end
        default: push = is_ofifo(reg_addr) && (r.cnt != CW'(OFIFO_DEPTH));
      endcase
    end

    if (push) begin
      n.mem[r.wp] = reg_wdata;
      n.wp        = r.wp + PW'(1);
    end
    if (pop) begin
      n.rp = r.rp + PW'(1);
    end
    n.cnt = r.cnt + CW'(push) - CW'(pop);

    set[0] = (r.cnt != '0) && (n.cnt == '0);
    set[1] = line_evt;
    set[2] = frame_evt;
    set[3] = start_evt;
    n.flags = (r.flags & ~clr) | set;

    if (start_evt && r.stretch_en) begin
      n.stretch = 1'b1;
    end else if (!n.stretch_en || !n.flags[3]) begin
      n.stretch = 1'b0;
    end

    // Second base only alternates once software has programmed it
    if (frame_evt && r.base1_set) begin
      n.base_sel = ~r.base_sel;
    end
    n.act_base = n.base_sel ? n.base1 : n.base0;

    n.clk_oe = (n.ln_en & ~n.clk_drv) | n.stretch;
    n.dat_oe = n.ln_en & ~n.dat_drv;
    n.irq    = |(n.flags & n.mask);

    if (reg_rd_en) begin
      n.rdata = '0;
      case (reg_addr)
        `VPSC_OFS_STATUS: n.rdata = stat_w;
        `VPSC_OFS_IRQ: begin
          n.rdata[3:0]                     = r.flags;
          n.rdata[`VPSC_IRQ_MASK_LSB +: 4] = r.mask;
          n.rdata[`VPSC_IRQ_STRETCH]       = r.stretch_en;
        end
        `VPSC_OFS_BASE0:  n.rdata[21:0] = r.base0;
        `VPSC_OFS_BASE1:  n.rdata[21:0] = r.base1;
        `VPSC_OFS_XADDR:  n.rdata[23:0] = {r.xkind, r.xaddr};
        `VPSC_OFS_XDATA:  n.rdata = r.xdata;
        `VPSC_OFS_NIBBLE: n.rdata[7:0] = {r.nb_in, r.nb_out};
        `VPSC_OFS_LINES: begin
          n.rdata[4:0]                      = line_w;
          n.rdata[`VPSC_LN_MIRROR_LSB +: 5] = line_w;
        end
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r          <= '0;
      r.strobe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata              = r.rdata;
  assign irq_req                = r.irq;
  assign two_wire_clock_line_o  = 1'b0;
  assign two_wire_clock_line_oe = r.clk_oe;
  assign two_wire_data_line_o   = 1'b0;
  assign two_wire_data_line_oe  = r.dat_oe;
  assign port_data_lines_o      = {4'h0, r.nb_out};
  assign port_data_lines_oe     = {4'h0, {4{r.nb_oe}}};
  assign nibble_port_strobe_n   = r.strobe_n;
  assign active_base_addr       = r.act_base;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  property p_free;
    reg_rd_en && reg_addr == `VPSC_OFS_STATUS |=>
      CW'(reg_rdata[3:0]) + $past(r.cnt) == CW'(OFIFO_DEPTH);
  endproperty
  a_free: assert property (p_free) else $error("free slot count wrong");

  property p_full;
    reg_rd_en && reg_addr == `VPSC_OFS_STATUS && r.cnt == CW'(OFIFO_DEPTH) |=>
      reg_rdata[`VPSC_ST_FULL] && !reg_rdata[`VPSC_ST_EMPTY];
  endproperty
  a_full: assert property (p_full) else $error("full bit wrong");

  property p_empty;
    reg_rd_en && reg_addr == `VPSC_OFS_STATUS && r.cnt == '0 |=>
      reg_rdata[`VPSC_ST_EMPTY] && !reg_rdata[`VPSC_ST_ONE] && reg_rdata[3];
  endproperty
  a_empty: assert property (p_empty) else $error("empty bit wrong");

  property p_one;
    reg_rd_en && reg_addr == `VPSC_OFS_STATUS && r.cnt == CW'(1) |=>
      reg_rdata[`VPSC_ST_ONE] && !reg_rdata[`VPSC_ST_EMPTY];
  endproperty
  a_one: assert property (p_one) else $error("one-left bit wrong");

  property p_empty_flag;
    (r.cnt != '0) ##1 (r.cnt == '0) |-> r.flags[0];
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag missed");

  property p_line_flag;
    line_evt |=> r.flags[1] ##1 (r.flags[1] || $past(reg_wr_en));
  endproperty
  a_line_flag: assert property (p_line_flag) else $error("line flag missed");

  property p_clear;
    reg_wr_en && reg_addr == `VPSC_OFS_IRQ && reg_wdata[2] && !frame_evt |=> !r.flags[2];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_irq;
    |(r.flags & r.mask) |-> irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output low");

  property p_stretch;
    start_evt && r.stretch_en |=>
      two_wire_clock_line_oe && r.flags[3];
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held");

  property p_strobe;
    reg_wr_en && reg_addr == `VPSC_OFS_NIBBLE |=>
      !nibble_port_strobe_n [*4];
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not pulsed");

  property p_latch;
    $rose(nibble_port_strobe_n) |-> r.nb_in == $past(r.nb_s2);
  endproperty
  a_latch: assert property (p_latch) else $error("input nibble not latched");

  property p_cdata;
    r.xs == VPSC_XS_IDLE && !r.x_pend && r.cnt != '0 |=>
      r.lk_kind == VPSC_TK_CDATA_WR && r.xs == VPSC_XS_BUSY;
  endproperty
  a_cdata: assert property (p_cdata) else $error("no compressed write");

  property p_launch;
    r.xs == VPSC_XS_IDLE && r.x_pend |=>
      r.req_tgl != $past(r.req_tgl) && r.lk_wdata == $past(r.xdata);
  endproperty
  a_launch: assert property (p_launch) else $error("transaction not launched");
endmodule

// *** tb/vpsc_dec_model.sv ***
// Decoder model on the far side of the link handshake
module vpsc_dec_model (
  input  logic                 link_clk,
  input  logic                 reset_n,
  input  logic                 stall,
  input  logic                 dec_req,
  input  vpsc_pkg::vpsc_kind_t dec_kind,
  input  logic [20:0]          dec_addr,
  input  logic [31:0]          dec_wdata,
  output logic                 dec_ack,
  output logic [31:0]          dec_rdata,
  output int                   n_done,
  output logic [2:0]           last_kind,
  output logic [31:0]          last_wdata
);
  import vpsc_pkg::*;
  logic [1:0] wait_r;
  always @(posedge link_clk) begin
    if (!reset_n) begin
      dec_ack <= 1'b0;
      n_done <= 0;
      wait_r <= 2'h0;
      dec_rdata <= 32'h0;
    end else if (dec_ack) begin
      dec_ack <= 1'b0;
      // Read data is not held past the acknowledge
      dec_rdata <= ~dec_rdata;
      n_done <= n_done + 1;
      last_kind <= dec_kind;
      last_wdata <= dec_wdata;
    end else if (dec_req && !stall) begin
      wait_r <= wait_r + 2'h1;
      if (wait_r == 2'h2) begin
        wait_r <= 2'h0;
        dec_ack <= 1'b1;
        dec_rdata <= {11'h0, dec_addr} ^ 32'h5a5a0000;
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the video port status and control block
`include "vpsc_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import vpsc_pkg::*;
  logic        sys_clk = 0, link_clk = 0, reset_n = 0, stall = 0;
  logic [15:0] reg_addr = 16'h0;
  logic        reg_wr_en = 0, reg_rd_en = 0, irq_req;
  logic [31:0] reg_wdata = 0, reg_rdata, dec_wdata, dec_rdata, last_wdata;
  logic [3:0]  lvl0 = 0, lvl1 = 0;
  logic        parity = 0, hsync = 0, vsync = 0, dat_pull = 1;
  logic        clk_oe, dat_oe, clk_o, dat_o, strobe_n, dec_req, dec_ack;
  logic [7:0]  pd_in, pd_o, pd_oe;
  logic [21:0] base;
  logic [20:0] dec_addr;
  logic [2:0]  last_kind;
  vpsc_kind_t  dec_kind;
  int          n_fail = 0, tests_run = 0, n_done;
  logic [3:0]  lv0 [3] = '{4'h1, 4'h2, 4'h8};
  logic [3:0]  lv1 [3] = '{4'h1, 4'h8, 4'h0};
  logic [31:0] est [3] = '{32'h80401008, 32'h20001008, 32'h40001008};

  always #5 sys_clk = ~sys_clk;
  always #62.5 link_clk = ~link_clk;
  // Far-side register drives the upper lines only while the strobe is low
  assign pd_in = {strobe_n ? 4'h0 : 4'h5, 4'h0};

  vpsc_video_port vpsc_video_port_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .link_clk(link_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_req(irq_req), .vid_fifo0_level(lvl0), .vid_fifo1_level(lvl1),
    .field_parity_pin(parity), .hsync_pin(hsync), .vsync_pin(vsync),
    .two_wire_clock_line_i(clk_oe ? clk_o : 1'b1), .two_wire_clock_line_o(clk_o),
    .two_wire_clock_line_oe(clk_oe), .two_wire_data_line_i(dat_oe ? dat_o : dat_pull),
    .two_wire_data_line_o(dat_o), .two_wire_data_line_oe(dat_oe),
    .port_data_lines_i(pd_in), .port_data_lines_o(pd_o), .port_data_lines_oe(pd_oe),
    .nibble_port_strobe_n(strobe_n), .active_base_addr(base), .dec_req(dec_req),
    .dec_kind(dec_kind), .dec_addr(dec_addr), .dec_wdata(dec_wdata),
    .dec_ack(dec_ack), .dec_rdata(dec_rdata));

  vpsc_dec_model vpsc_dec_model_inst (.link_clk(link_clk), .reset_n(reset_n),
    .stall(stall), .dec_req(dec_req), .dec_kind(dec_kind), .dec_addr(dec_addr),
    .dec_wdata(dec_wdata), .dec_ack(dec_ack), .dec_rdata(dec_rdata),
    .n_done(n_done), .last_kind(last_kind), .last_wdata(last_wdata));

  task automatic end_sim;
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic wait_done(input int n);
    for (int i = 0; i < 3000 && n_done < n; i++) @(posedge sys_clk);
    if (n_done < n) begin
      n_fail++;
      $display("Error %0t: link transfer timed out", $time);
      end_sim();
    end
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic sync_pulse(input bit v);
    @(posedge link_clk);
    if (v) vsync <= 1'b1; else hsync <= 1'b1;
    @(posedge link_clk);
    vsync <= 1'b0;
    hsync <= 1'b0;
    repeat (3) @(posedge link_clk);
  endtask

  initial begin
    // Link domain needs three of its own edges inside reset
    repeat (40) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd_chk(`VPSC_OFS_STATUS, 32'h40001008);
    rd_chk(`VPSC_OFS_IRQ, 32'h0);
    rd_chk(16'hff60, 32'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      lvl0 <= lv0[i];
      lvl1 <= lv1[i];
      rd_chk(`VPSC_OFS_STATUS, est[i]);
    end
    parity <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_chk(`VPSC_OFS_STATUS, 32'h40101008);
    wr(`VPSC_OFS_BASE0, 32'h00123458);
    wr(`VPSC_OFS_BASE1, 32'h00000100);
    rd_chk(`VPSC_OFS_BASE0, 32'h00123458);
    chk(32'(base), 32'h123458);
    sync_pulse(1'b1);
    rd_chk(`VPSC_OFS_STATUS, 32'h40301008);
    chk(32'(base), 32'h100);
    rd_chk(`VPSC_OFS_IRQ, 32'h4);
    chk(32'(irq_req), 32'h0);
    wr(`VPSC_OFS_IRQ, 32'h00060000);
    #1 chk(32'(irq_req), 32'h1);
    rd_chk(`VPSC_OFS_IRQ, 32'h00060004);
    sync_pulse(1'b0);
    rd_chk(`VPSC_OFS_IRQ, 32'h00060006);
    wr(`VPSC_OFS_IRQ, 32'h00060006);
    rd_chk(`VPSC_OFS_IRQ, 32'h00060000);
    chk(32'(irq_req), 32'h0);
    wr(`VPSC_OFS_IRQ, 32'h01080000);
    dat_pull <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd_chk(`VPSC_OFS_IRQ, 32'h01080008);
    chk(32'({clk_oe, irq_req}), 32'h3);
    dat_pull <= 1'b1;
    wr(`VPSC_OFS_IRQ, 32'h01080008);
    repeat (2) @(posedge sys_clk);
    chk(32'(clk_oe), 32'h0);
    wr(`VPSC_OFS_LINES, 32'h12);
    #1 chk(32'({clk_oe, dat_oe}), 32'h2);
    // Sense bits pass a two-flop synchroniser
    repeat (2) @(posedge sys_clk);
    rd_chk(`VPSC_OFS_LINES, 32'h1a1a);
    wr(`VPSC_OFS_LINES, 32'h13);
    repeat (2) @(posedge sys_clk);
    rd_chk(`VPSC_OFS_LINES, 32'h1f1f);
    wr(`VPSC_OFS_NIBBLE, 32'ha);
    #1 chk(32'({strobe_n, pd_oe, pd_o}), 32'h0f0a);
    repeat (5) @(posedge sys_clk);
    chk(32'({strobe_n, pd_oe}), 32'h100);
    rd_chk(`VPSC_OFS_NIBBLE, 32'h5a);
    wr(`VPSC_OFS_XADDR, 32'h00001234);
    wr(`VPSC_OFS_XDATA, 32'hcafe0001);
    wait_done(1);
    chk(32'(last_kind), 32'h0);
    chk(last_wdata, 32'hcafe0001);
    wr(`VPSC_OFS_XADDR, 32'h00201234);
    wr(`VPSC_OFS_XDATA, 32'h0);
    wait_done(2);
    chk(32'(last_kind), 32'h1);
    rd_chk(`VPSC_OFS_XADDR, 32'h00201234);
    rd_chk(`VPSC_OFS_XDATA, 32'h5a5a1234);
    stall <= 1'b1;
    wr(`VPSC_OFS_OFIFO, 32'h11);
    rd_chk(`VPSC_OFS_STATUS, 32'h40302007);
    for (int i = 0; i < 8; i++) wr(16'hff40 + 16'(4 * i), 32'(i));
    rd_chk(`VPSC_OFS_STATUS, 32'h40300800);
    stall <= 1'b0;
    wait_done(10);
    chk(32'(last_kind), 32'h6);
    chk(last_wdata, 32'h6);
    rd_chk(`VPSC_OFS_STATUS, 32'h40301008);
    rd_chk(`VPSC_OFS_IRQ, 32'h01080001);
    repeat (200) @(posedge sys_clk);
    chk(32'(n_done), 32'd10);
    end_sim();
  end
endmodule
